// *** rtl/ntir_pkg.sv ***
// package: register map, field layout and bus carriers for the tuning bank
package ntir_pkg;
  localparam int          DATA_W          = 16;
  localparam int          BUS_W           = 32;
  // offsets are not all multiples of four: they are indexes, byte address = 4 * index
  localparam logic [7:0]  IDX_INIT_FIVE   = 8'h0a;
  localparam logic [7:0]  IDX_INIT_THREE  = 8'h12;
  localparam logic [7:0]  IDX_INIT_FOUR   = 8'h13;
  localparam logic [7:0]  IDX_MIX_CTRL    = 8'hfb;
  localparam logic [7:0]  IDX_PHASE_LOW   = 8'hfc;
  localparam logic [7:0]  IDX_PH_HI_FR_LO = 8'hfd;
  localparam logic [7:0]  IDX_FREQ_HIGH   = 8'hfe;
  localparam logic [7:0]  IDX_BANK_SEL    = 8'hff;
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_MSB         = 9;
  localparam int          BANK_SEL_BIT    = 0;
  localparam int          INIT3_BIT       = 6;
  localparam int          INIT4_BIT       = 15;
  localparam int          INIT5_BIT       = 14;
  localparam int          MIX_EN_BIT      = 0;
  localparam int          PSYNC_BIT       = 3;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam int          SYNC_STAGES     = 3;

  typedef struct packed {
    logic [23:0] phase;
    logic [23:0] freq;
  } ntir_tune_t;

  typedef struct packed {
    logic init3;
    logic init4;
    logic init5;
  } ntir_init_t;
endpackage : ntir_pkg

// *** rtl/ntir_sync_pulse.sv ***
// module: three-stage pin synchroniser with agreed-edge pulse detect
`timescale 1ns/1ps
module ntir_sync_pulse #(
  parameter int STAGES = ntir_pkg::SYNC_STAGES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      rise
);
  logic [STAGES-1:0] sync_q;
  logic              level;

  // the first stage feeds only the second
  wire               both_hi = sync_q[STAGES-1] & sync_q[STAGES-2];
  wire               both_lo = ~(sync_q[STAGES-1] | sync_q[STAGES-2]);

  // level moves only when the last two stages agree, so a lone glitch is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= '0;
      level  <= 1'b0;
      rise   <= 1'b0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], pin};
      level  <= both_hi | (level & ~both_lo);
      rise   <= both_hi & ~level;
    end
  end
endmodule : ntir_sync_pulse

// *** rtl/ntir_regs.sv ***
// module: oscillator tuning and initialization register bank behind an AHB-Lite slave
// How it works
// R1 - the low sixteen bits of the phase count live in the whole of the first tuning register.
// R2 - phase count bits 23 to 16 sit in bits 7 to 0 of the second tuning register.
// R3 - the lowest byte of the frequency word sits in bits 15 to 8 of the second tuning register.
// R4 - the upper sixteen frequency bits fill the third tuning register, making 24 bits.
// R5 - software sets bit 6 of bank-two register 12h while initializing and clears it after.
// R6 - software sets bit 15 of bank-two register 13h while initializing and clears it after.
// R7 - software sets bit 14 of bank-two register 0Ah while initializing and clears it after.
// R8 - software keeps reserved bits at zero and preserves them on every write.
// R9 - every register of both banks resets to zero.
// R10 - bank two is an address space of its own, apart from bank one.
// R11 - the mixer enable bit turns the down converter off at zero and on at one.
// R12 - sync select zero syncs on a single pin pulse; one syncs on the first of a train.
// R13 - every field reads back what was written, sixteen bits wide, through the register port.
`timescale 1ns/1ps
module ntir_regs (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        SAMPLE_SYNC_PIN,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output ntir_pkg::ntir_tune_t TUNE,
  output ntir_pkg::ntir_init_t INIT,
  output logic             DOWNCONV_ENABLE,
  output logic             OSC_SYNC
);
  // full 16-bit storage: reserved bits are kept as written (read/write)
  logic [15:0] init_five_ctrl;
  logic [15:0] init_three_ctrl;
  logic [15:0] init_four_ctrl;
  logic [15:0] mix_ctrl;
  logic [15:0] osc_phase_low;
  logic [15:0] osc_phase_high_freq_low;
  logic [15:0] osc_freq_high;
  logic [15:0] bank_sel;
  logic        wr_pend;
  logic [7:0]  wr_idx;
  logic        sync_rise;
  logic        sync_armed;

  wire        addr_ok   = HSEL & HREADY & (HTRANS == ntir_pkg::HTRANS_NONSEQ);
  wire [7:0]  addr_idx  = HADDR[ntir_pkg::IDX_MSB:ntir_pkg::IDX_LSB];
  wire        bank_two  = bank_sel[ntir_pkg::BANK_SEL_BIT];
  wire [15:0] wdata     = HWDATA[15:0];

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx,
                               input logic bank, input logic want_two);
    hit = (idx == reg_idx) & (bank == want_two);
  endfunction : hit

  // R10 bank two holds 0Ah/12h/13h; the selector reads in both banks
  wire w_five   = wr_pend & hit(wr_idx, ntir_pkg::IDX_INIT_FIVE, bank_two, 1'b1);
  wire w_three  = wr_pend & hit(wr_idx, ntir_pkg::IDX_INIT_THREE, bank_two, 1'b1);
  wire w_four   = wr_pend & hit(wr_idx, ntir_pkg::IDX_INIT_FOUR, bank_two, 1'b1);
  wire w_mix    = wr_pend & hit(wr_idx, ntir_pkg::IDX_MIX_CTRL, bank_two, 1'b0);
  wire w_plow   = wr_pend & hit(wr_idx, ntir_pkg::IDX_PHASE_LOW, bank_two, 1'b0);
  wire w_phfl   = wr_pend & hit(wr_idx, ntir_pkg::IDX_PH_HI_FR_LO, bank_two, 1'b0);
  wire w_fhigh  = wr_pend & hit(wr_idx, ntir_pkg::IDX_FREQ_HIGH, bank_two, 1'b0);
  wire w_bank   = wr_pend & (wr_idx == ntir_pkg::IDX_BANK_SEL);

  // read selects are decoded in the address phase so data stands in the data phase
  wire        r_bank  = (addr_idx == ntir_pkg::IDX_BANK_SEL);
  wire        r_five  = hit(addr_idx, ntir_pkg::IDX_INIT_FIVE, bank_two, 1'b1);
  wire        r_three = hit(addr_idx, ntir_pkg::IDX_INIT_THREE, bank_two, 1'b1);
  wire        r_four  = hit(addr_idx, ntir_pkg::IDX_INIT_FOUR, bank_two, 1'b1);
  wire        r_mix   = hit(addr_idx, ntir_pkg::IDX_MIX_CTRL, bank_two, 1'b0);
  wire        r_plow  = hit(addr_idx, ntir_pkg::IDX_PHASE_LOW, bank_two, 1'b0);
  wire        r_phfl  = hit(addr_idx, ntir_pkg::IDX_PH_HI_FR_LO, bank_two, 1'b0);
  wire        r_fhigh = hit(addr_idx, ntir_pkg::IDX_FREQ_HIGH, bank_two, 1'b0);

  // selects are one-hot, so an and-or mux is enough; unmapped reads zero
  wire [15:0] rd_mux  = ({ntir_pkg::DATA_W{r_bank}}  & bank_sel)
                      | ({ntir_pkg::DATA_W{r_five}}  & init_five_ctrl)
                      | ({ntir_pkg::DATA_W{r_three}} & init_three_ctrl)
                      | ({ntir_pkg::DATA_W{r_four}}  & init_four_ctrl)
                      | ({ntir_pkg::DATA_W{r_mix}}   & mix_ctrl)
                      | ({ntir_pkg::DATA_W{r_plow}}  & osc_phase_low)
                      | ({ntir_pkg::DATA_W{r_phfl}}  & osc_phase_high_freq_low)
                      | ({ntir_pkg::DATA_W{r_fhigh}} & osc_freq_high);

  // zero-wait slave, always OKAY
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend   <= 1'b0;
      wr_idx    <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_pend <= addr_ok & HWRITE;
      wr_idx  <= addr_idx;
      if (addr_ok & ~HWRITE) begin
        HRDATA <= {16'h0000, rd_mux}; // R13
      end
    end
  end

  // one short block per register; strobes fire at the end of the data phase
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_five_ctrl <= ntir_pkg::REG_RESET; // R9
    end else if (w_five) begin
      init_five_ctrl <= wdata; // R7
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_three_ctrl <= ntir_pkg::REG_RESET; // R9
    end else if (w_three) begin
      init_three_ctrl <= wdata; // R5
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_four_ctrl <= ntir_pkg::REG_RESET; // R9
    end else if (w_four) begin
      init_four_ctrl <= wdata; // R6
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mix_ctrl <= ntir_pkg::REG_RESET; // R9
    end else if (w_mix) begin
      mix_ctrl <= wdata; // R11 R12
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_phase_low <= ntir_pkg::REG_RESET; // R9
    end else if (w_plow) begin
      osc_phase_low <= wdata; // R1
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_phase_high_freq_low <= ntir_pkg::REG_RESET; // R9
    end else if (w_phfl) begin
      osc_phase_high_freq_low <= wdata; // R2 R3
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_freq_high <= ntir_pkg::REG_RESET; // R9
    end else if (w_fhigh) begin
      osc_freq_high <= wdata; // R4
    end
  end

  // the selector answers in both banks, or software could never switch back
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bank_sel <= ntir_pkg::REG_RESET; // R9
    end else if (w_bank) begin
      bank_sel <= wdata; // R10
    end
  end

  ntir_sync_pulse u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .pin   (SAMPLE_SYNC_PIN),
    .rise  (sync_rise)
  );

  // periodic mode takes only the first pulse of a train; re-armed by rewriting the control
  wire periodic  = mix_ctrl[ntir_pkg::PSYNC_BIT];
  wire sync_take = sync_rise & (~periodic | sync_armed); // R12

  // a rewrite of the control in the same cycle as a taken pulse leaves it armed
  wire next_armed = w_mix | (sync_armed & ~(sync_take & periodic));

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_armed <= 1'b1;
    end else begin
      sync_armed <= next_armed; // R12
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OSC_SYNC <= 1'b0;
    end else begin
      OSC_SYNC <= sync_take; // R12
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DOWNCONV_ENABLE <= 1'b0;
    end else begin
      DOWNCONV_ENABLE <= mix_ctrl[ntir_pkg::MIX_EN_BIT]; // R11
    end
  end

  // outputs are registered copies, one cycle behind their storage
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TUNE <= '0;
    end else begin
      TUNE.phase <= {osc_phase_high_freq_low[7:0], osc_phase_low}; // R1 R2
      TUNE.freq  <= {osc_freq_high, osc_phase_high_freq_low[15:8]}; // R3 R4
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      INIT <= '0;
    end else begin
      INIT.init3 <= init_three_ctrl[ntir_pkg::INIT3_BIT]; // R5
      INIT.init4 <= init_four_ctrl[ntir_pkg::INIT4_BIT]; // R6
      INIT.init5 <= init_five_ctrl[ntir_pkg::INIT5_BIT]; // R7
    end
  end
endmodule : ntir_regs

// *** verification/ntir_regs_monitor.sv ***
// checker: bus answer, output causes, reset values and sync pulses
`timescale 1ns/1ps
module ntir_regs_monitor (
  input wire logic                 CORE_CLK,
  input wire logic                 RST_N,
  input wire logic                 HSEL,
  input wire logic [1:0]           HTRANS,
  input wire logic                 HWRITE,
  input wire logic                 HREADY,
  input wire logic                 SAMPLE_SYNC_PIN,
  input wire logic [31:0]          HRDATA,
  input wire logic                 HREADYOUT,
  input wire logic                 HRESP,
  input wire ntir_pkg::ntir_tune_t TUNE,
  input wire ntir_pkg::ntir_init_t INIT,
  input wire logic                 DOWNCONV_ENABLE,
  input wire logic                 OSC_SYNC
);
  logic       take;
  logic       rd_h;
  logic [3:0] wr_h;
  logic [7:0] pin_h;
  assign take = HSEL && HREADY && HTRANS == ntir_pkg::HTRANS_NONSEQ;
  // short history: outputs may only move a few cycles after their cause
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_h  <= 1'b0;
      wr_h  <= 4'h0;
      pin_h <= 8'h0;
    end else begin
      rd_h  <= take && !HWRITE;
      wr_h  <= {wr_h[2:0], take && HWRITE};
      pin_h <= {pin_h[6:0], SAMPLE_SYNC_PIN};
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence one_pulse_s;
    OSC_SYNC ##1 !OSC_SYNC;
  endsequence
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not okay");
  rdata_upper_a: assert property (HRDATA[31:16] == 16'h0) else $error("upper read bits");
  rdata_cause_a: assert property ($changed(HRDATA) |-> rd_h) else $error("stray read data");
  tune_cause_a: assert property ($changed(TUNE) |-> |wr_h) else $error("stray tune change");
  init_cause_a: assert property ($changed(INIT) |-> |wr_h) else $error("stray init change");
  mix_cause_a: assert property ($changed(DOWNCONV_ENABLE) |-> |wr_h) else $error("stray enable");
  reset_zero_a: assert property (disable iff (1'b0) !RST_N |-> TUNE == '0 && INIT == '0
    && !DOWNCONV_ENABLE) else $error("output not cleared in reset");
  sync_pulse_a: assert property (OSC_SYNC |-> one_pulse_s) else $error("sync pulse too long");
  sync_cause_a: assert property (OSC_SYNC |-> |pin_h) else $error("sync without pin");
endmodule : ntir_regs_monitor
bind ntir_regs ntir_regs_monitor mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .SAMPLE_SYNC_PIN(SAMPLE_SYNC_PIN),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TUNE(TUNE), .INIT(INIT),
  .DOWNCONV_ENABLE(DOWNCONV_ENABLE), .OSC_SYNC(OSC_SYNC));

// *** verification/test_nco_tuning_and_init_registers.sv ***
// testbench: register access, tuning outputs, init bits and sync pulses
`timescale 1ns/1ps
module test_nco_tuning_and_init_registers;
  logic                 CORE_CLK = 1'b0;
  logic                 RST_N = 1'b1;
  logic                 HSEL = 1'b0;
  logic [31:0]          HADDR = 32'h0;
  logic [1:0]           HTRANS = 2'h0;
  logic                 HWRITE = 1'b0;
  logic [2:0]           HSIZE = 3'h0;
  logic [31:0]          HWDATA = 32'h0;
  logic                 SAMPLE_SYNC_PIN = 1'b0;
  logic [31:0]          HRDATA;
  logic                 HREADYOUT;
  logic                 HRESP;
  ntir_pkg::ntir_tune_t TUNE;
  ntir_pkg::ntir_init_t INIT;
  logic                 DOWNCONV_ENABLE;
  logic                 OSC_SYNC;
  int                   n_errors = 0;
  int                   checks = 0;
  int                   n = 0;
  int                   n0;
  logic [7:0]           ix [3] = '{8'h12, 8'h13, 8'h0a};
  logic [15:0]          dv [3] = '{16'h0040, 16'h8000, 16'h4000};
  ntir_regs dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .SAMPLE_SYNC_PIN(SAMPLE_SYNC_PIN), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TUNE(TUNE), .INIT(INIT),
    .DOWNCONV_ENABLE(DOWNCONV_ENABLE), .OSC_SYNC(OSC_SYNC));
  initial forever #12.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) n <= n + int'(OSC_SYNC);
  task automatic end_of_test;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge CORE_CLK);
    while (HREADYOUT !== 1'b1 && k < 50) begin
      k++;
      @(posedge CORE_CLK);
    end
    if (HREADYOUT !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask : edge_rdy
  // a write leaves one idle cycle so a read-back sees the new value
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
    HTRANS <= ntir_pkg::HTRANS_NONSEQ;
    HADDR  <= {22'h0, idx, 2'h0};
    HWRITE <= w;
    HSIZE  <= ntir_pkg::HSIZE_WORD;
    edge_rdy();
    HTRANS <= 2'h0;
    HWDATA <= {16'h0, d};
    edge_rdy();
    if (w) @(posedge CORE_CLK);
  endtask : xfer
  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    xfer(1'b0, idx, 16'h0);
    chk({16'h0, HRDATA}, {32'h0, e});
  endtask : rd
  task automatic pulse;
    SAMPLE_SYNC_PIN <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    SAMPLE_SYNC_PIN <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
  endtask : pulse
  initial begin
    RST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    HSEL  <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ntir_pkg::IDX_MIX_CTRL + 8'(i), 16'h0);
    xfer(1'b1, ntir_pkg::IDX_PHASE_LOW, 16'h1234);
    xfer(1'b1, ntir_pkg::IDX_PH_HI_FR_LO, 16'hab56);
    xfer(1'b1, ntir_pkg::IDX_FREQ_HIGH, 16'hcdef);
    rd(ntir_pkg::IDX_PHASE_LOW, 16'h1234);
    rd(ntir_pkg::IDX_PH_HI_FR_LO, 16'hab56);
    rd(ntir_pkg::IDX_FREQ_HIGH, 16'hcdef);
    chk(TUNE, {24'h561234, 24'hcdefab});
    xfer(1'b1, ntir_pkg::IDX_INIT_THREE, 16'h0040);
    rd(ntir_pkg::IDX_INIT_THREE, 16'h0);
    xfer(1'b1, ntir_pkg::IDX_BANK_SEL, 16'h0001);
    rd(ntir_pkg::IDX_PHASE_LOW, 16'h0);
    for (int i = 0; i < 3; i++) begin
      rd(ix[i], 16'h0);
      xfer(1'b1, ix[i], dv[i]);
      rd(ix[i], dv[i]);
      chk({45'h0, INIT}, {45'h0, 3'(3'b111 << (2 - i))});
    end
    // normal operation: init bits cleared again, reserved bits left at zero
    for (int i = 0; i < 3; i++) xfer(1'b1, ix[i], 16'h0000);
    rd(ix[2], 16'h0);
    chk({45'h0, INIT}, 48'h0);
    xfer(1'b1, ntir_pkg::IDX_BANK_SEL, 16'h0000);
    xfer(1'b1, ntir_pkg::IDX_MIX_CTRL, 16'h0001);
    rd(ntir_pkg::IDX_MIX_CTRL, 16'h0001);
    chk({47'h0, DOWNCONV_ENABLE}, 48'h1);
    n0 = n;
    pulse();
    pulse();
    chk(48'(n - n0), 48'h2);
    xfer(1'b1, ntir_pkg::IDX_MIX_CTRL, 16'h0008);
    n0 = n;
    pulse();
    pulse();
    chk(48'(n - n0), 48'h1);
    chk({47'h0, DOWNCONV_ENABLE}, 48'h0);
    RST_N <= 1'b0;
    @(posedge CORE_CLK);
    chk(TUNE, 48'h0);
    RST_N <= 1'b1;
    rd(ntir_pkg::IDX_FREQ_HIGH, 16'h0);
    end_of_test();
  end
endmodule : test_nco_tuning_and_init_registers
